/* hw/dtl_timing_regs.svh */
// Register map, field positions, reset value and timing bases of the timing-low block.
// Assumes inclusion by bare name from the block's design files.
`ifndef DTL_TIMING_REGS_SVH
`define DTL_TIMING_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DTL_OFF_CHAN_A  9'h088
`define DTL_OFF_CHAN_B  9'h188

// ----------------------------------------
// Reset value and writable bits
// ----------------------------------------
`define DTL_RESET       32'hff000000
`define DTL_WR_MASK     32'hfffff000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DTL_CLK_OFF_HI  31
`define DTL_CLK_OFF_LO  24
`define DTL_RRD_HI      23
`define DTL_RRD_LO      22
`define DTL_WR_HI       21
`define DTL_WR_LO       20
`define DTL_RC_EXT      20
`define DTL_RC_HI       19
`define DTL_RC_LO       16
`define DTL_RAS_HI      15
`define DTL_RAS_LO      12

// ----------------------------------------
// Mode and timing bases in memory clocks
// ----------------------------------------
`define DTL_FREQ_1066   3'h4
`define DTL_RRD_BASE    6'h02
`define DTL_RRD_ALT     6'h04
`define DTL_WR_BASE     6'h03
`define DTL_RC_BASE     6'h0b
`define DTL_RAS_BASE    6'h03
`define DTL_RAS_ALT     6'h0f
`define DTL_CNT_ONE     6'h01
`define DTL_CNT_ZERO    6'h00

`endif

/* hw/dtl_pkg.sv */
// Types shared by the timing-low block and its users.
// Assumes nothing of its surroundings.
package dtl_pkg;

   // ----------------------------------------
   // Bus slave states
   // ----------------------------------------
   typedef enum logic [1:0] {
      DTL_IDLE = 2'b01,
      DTL_RESP = 2'b10
   } dtl_bus_state_t;

   // ----------------------------------------
   // Scheduler command kinds
   // ----------------------------------------
   typedef enum logic [1:0] {
      DTL_CMD_ACT     = 2'h0,
      DTL_CMD_PRE     = 2'h1,
      DTL_CMD_REF     = 2'h2,
      DTL_CMD_WR_LAST = 2'h3
   } dtl_cmd_t;

endpackage

/* hw/dtl_timing_low.sv */
// Two-channel timing-low register with its per-bank command spacing guard.
// Assumes one clock that is the memory clock, and an Avalon-MM master with waitrequest.
`timescale 1ns/1ns
`default_nettype none
`include "dtl_timing_regs.svh"

// Notes on behaviour
// - Reset loads each register with ones in the top byte and zeros below, so all clock pairs start off.
// - A one in a bit of the clock-off mask in bits 31 to 24 stops that clock pair, a zero lets it run.
// - The register at the lower offset drives channel A clocks and the one at the higher offset channel B.
// - Activates to different banks are spaced by at least the interval in bits 23 to 22.
// - In plain second-gen mode that interval field decodes as 2, 3, 4 and 5 clocks.
// - In third-gen mode or at frequency code 100b the interval field decodes as 4 to 7 clocks.
// - A bank is not precharged before write recovery, bits 21 to 20 decoding as 3 to 6 clocks, ends.
// - The write recovery field is used only with third-gen off and frequency code not 100b.
// - Otherwise bit 21 is reserved, bit 20 tops the row cycle field and recovery comes from elsewhere.
// - An activate or refresh to a bank waits at least the row cycle time after its last activate.
// - In plain second-gen mode the four-bit row cycle field decodes linearly from 11 to 26 clocks.
// - In the other modes the five-bit row cycle field in bits 20 to 16 decodes from 11 to 42 clocks.
// - A precharge to a bank waits at least the row active time in bits 15 to 12 after its activate.
module dtl_timing_low #(
   parameter int BANKS  = 8,
   parameter int BANK_W = 3
) (
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic [8:0]             address,
   input  wire logic                   read,
   input  wire logic                   write,
   input  wire logic [31:0]            writedata,
   input  wire logic [3:0]             byteenable,
   output var  logic [31:0]            readdata,
   output var  logic                   waitrequest,
   input  wire logic                   third_gen_select,
   input  wire logic [2:0]             mem_clock_freq_code,
   input  wire logic [5:0]             wr_recovery_ext,
   input  wire logic                   cmd_valid,
   input  wire logic                   cmd_chan,
   input  wire logic [BANK_W-1:0]      cmd_bank,
   input  wire dtl_pkg::dtl_cmd_t      cmd_kind,
   output var  logic [1:0][BANKS-1:0]  act_ok,
   output var  logic [1:0][BANKS-1:0]  pre_ok,
   output var  logic [1:0][BANKS-1:0]  ref_ok,
   output var  logic [1:0][7:0]        memory_clock_out
);

   // ----------------------------------------
   // Field decoding
   // ----------------------------------------
   function automatic logic alt_mode(input logic g3, input logic [2:0] f);
      alt_mode = g3 || (f == `DTL_FREQ_1066);
   endfunction

   function automatic logic [5:0] rrd_clocks(input logic [31:0] r, input logic alt);
      logic [5:0] fld;
      fld = {4'h0, r[`DTL_RRD_HI:`DTL_RRD_LO]};
      rrd_clocks = alt ? `DTL_RRD_ALT + fld : `DTL_RRD_BASE + fld;
   endfunction

   function automatic logic [5:0] wr_clocks(input logic [31:0] r, input logic alt, input logic [5:0] ext);
      logic [5:0] fld;
      fld = {4'h0, r[`DTL_WR_HI:`DTL_WR_LO]};
      wr_clocks = alt ? ext : `DTL_WR_BASE + fld;
   endfunction

   function automatic logic [5:0] rc_clocks(input logic [31:0] r, input logic alt);
      logic [5:0] fld;
      fld = {1'b0, alt & r[`DTL_RC_EXT], r[`DTL_RC_HI:`DTL_RC_LO]};
      rc_clocks = `DTL_RC_BASE + fld;
   endfunction

   function automatic logic [5:0] ras_clocks(input logic [31:0] r, input logic alt);
      logic [5:0] fld;
      fld = {2'h0, r[`DTL_RAS_HI:`DTL_RAS_LO]};
      ras_clocks = alt ? `DTL_RAS_ALT + fld : `DTL_RAS_BASE + fld;
   endfunction

   function automatic logic [5:0] count_down(input logic [5:0] c);
      count_down = (c != `DTL_CNT_ZERO) ? c - `DTL_CNT_ONE : `DTL_CNT_ZERO;
   endfunction

   // ----------------------------------------
   // Write merge
   // ----------------------------------------
   function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
      merge_lanes = (old & ~m) | (d & m);
   endfunction

   // ----------------------------------------
   // Registers and bus slave
   // ----------------------------------------
   localparam int LANES  = 4;
   localparam int LANE_W = 8;

   logic [1:0][31:0]        timing;
   dtl_pkg::dtl_bus_state_t bus_state;
   logic                    hit_a;
   logic                    hit_b;
   logic [31:0]             lane_mask;
   logic                    alt;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign hit_a = (address == `DTL_OFF_CHAN_A);
   assign hit_b = (address == `DTL_OFF_CHAN_B);
   assign alt   = alt_mode(third_gen_select, mem_clock_freq_code);

   // ----------------------------------------
   // Byte lanes
   // ----------------------------------------
   always_comb begin
      lane_mask = 32'h00000000;
      for (int i = 0; i < LANES; i++) begin
         lane_mask[i*LANE_W +: LANE_W] = {LANE_W{byteenable[i]}};
      end
      lane_mask = lane_mask & `DTL_WR_MASK;
   end

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bus_state <= dtl_pkg::DTL_IDLE;
      end else begin
         unique case (bus_state)
            dtl_pkg::DTL_IDLE: begin
               if (read || write) begin
                  bus_state <= dtl_pkg::DTL_RESP;
               end
            end
            dtl_pkg::DTL_RESP: begin
               bus_state <= dtl_pkg::DTL_IDLE;
            end
            default: begin
               bus_state <= dtl_pkg::DTL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !(bus_state == dtl_pkg::DTL_IDLE && (read || write));
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         readdata <= 32'h00000000;
      end else if (bus_state == dtl_pkg::DTL_IDLE && read) begin
         if (hit_a) begin
            readdata <= timing[0];
         end else if (hit_b) begin
            readdata <= timing[1];
         end else begin
            readdata <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   for (genvar ch = 0; ch < 2; ch++) begin : g_reg
      logic addr_hit;

      assign addr_hit = (ch == 0) ? hit_a : hit_b;

      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            timing[ch] <= `DTL_RESET;
         end else if (bus_state == dtl_pkg::DTL_RESP && write && addr_hit) begin
            timing[ch] <= merge_lanes(timing[ch], writedata, lane_mask);
         end
      end
   end

   // ----------------------------------------
   // Per-channel clock gating and spacing
   // ----------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_chan
      logic              issue;
      logic              act_any;
      logic [5:0]        rrd_cnt;
      logic [5:0]        next_rrd_cnt;
      logic [BANK_W-1:0] last_bank;
      logic [BANK_W-1:0] cur_bank;

      assign issue    = cmd_valid && (cmd_chan == 1'(c));
      assign act_any  = issue && (cmd_kind == dtl_pkg::DTL_CMD_ACT) && act_ok[c][cmd_bank];
      assign cur_bank = act_any ? cmd_bank : last_bank;

      // ----------------------------------------
      // Clock gating
      // ----------------------------------------

      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            memory_clock_out[c] <= 8'h00;
         end else begin
            memory_clock_out[c] <= ~timing[c][`DTL_CLK_OFF_HI:`DTL_CLK_OFF_LO];
         end
      end

      // ----------------------------------------
      // Cross-bank spacing
      // ----------------------------------------
      always_comb begin
         next_rrd_cnt = count_down(rrd_cnt);
         if (act_any) begin
            next_rrd_cnt = rrd_clocks(timing[c], alt) - `DTL_CNT_ONE;
         end
      end

      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            rrd_cnt <= `DTL_CNT_ZERO;
         end else begin
            rrd_cnt <= next_rrd_cnt;
         end
      end

      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            last_bank <= '0;
         end else if (act_any) begin
            last_bank <= cmd_bank;
         end
      end

      // ----------------------------------------
      // Per-bank limits
      // ----------------------------------------
      for (genvar b = 0; b < BANKS; b++) begin : g_bank
         logic       hit;
         logic [5:0] rc_cnt;
         logic [5:0] ras_cnt;
         logic [5:0] wr_cnt;
         logic [5:0] next_rc_cnt;
         logic [5:0] next_ras_cnt;
         logic [5:0] next_wr_cnt;
         logic       next_act_ok;

         assign hit = issue && (cmd_bank == BANK_W'(b));

         // ----------------------------------------
         // Next counts
         // ----------------------------------------
         always_comb begin
            next_rc_cnt = count_down(rc_cnt);
            if (hit && cmd_kind == dtl_pkg::DTL_CMD_ACT && act_ok[c][b]) begin
               next_rc_cnt = rc_clocks(timing[c], alt) - `DTL_CNT_ONE;
            end
            if (hit && cmd_kind == dtl_pkg::DTL_CMD_REF && ref_ok[c][b]) begin
               next_rc_cnt = rc_clocks(timing[c], alt) - `DTL_CNT_ONE;
            end
         end

         always_comb begin
            next_ras_cnt = count_down(ras_cnt);
            if (hit && cmd_kind == dtl_pkg::DTL_CMD_ACT && act_ok[c][b]) begin
               next_ras_cnt = ras_clocks(timing[c], alt) - `DTL_CNT_ONE;
            end
         end

         always_comb begin
            next_wr_cnt = count_down(wr_cnt);
            if (hit && cmd_kind == dtl_pkg::DTL_CMD_WR_LAST) begin
               next_wr_cnt = wr_clocks(timing[c], alt, wr_recovery_ext) - `DTL_CNT_ONE;
            end
         end

         always_comb begin
            next_act_ok = (next_rc_cnt == `DTL_CNT_ZERO)
                          && (next_rrd_cnt == `DTL_CNT_ZERO || cur_bank == BANK_W'(b));
         end

         // ----------------------------------------
         // Limit state
         // ----------------------------------------
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               rc_cnt <= `DTL_CNT_ZERO;
            end else begin
               rc_cnt <= next_rc_cnt;
            end
         end

         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               ras_cnt <= `DTL_CNT_ZERO;
            end else begin
               ras_cnt <= next_ras_cnt;
            end
         end

         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               wr_cnt <= `DTL_CNT_ZERO;
            end else begin
               wr_cnt <= next_wr_cnt;
            end
         end

         // ----------------------------------------
         // Command flags
         // ----------------------------------------
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               act_ok[c][b] <= 1'b1;
            end else begin
               act_ok[c][b] <= next_act_ok;
            end
         end

         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               pre_ok[c][b] <= 1'b1;
            end else begin
               pre_ok[c][b] <= (next_ras_cnt == `DTL_CNT_ZERO) && (next_wr_cnt == `DTL_CNT_ZERO);
            end
         end

         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               ref_ok[c][b] <= 1'b1;
            end else begin
               ref_ok[c][b] <= (next_rc_cnt == `DTL_CNT_ZERO);
            end
         end
      end
   end

endmodule // dtl_timing_low
`default_nettype wire

/* testbench/dtl_timing_low_asserts.sv */
// Port checks for the timing-low block.
// Assumes a bind to dtl_timing_low, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module dtl_timing_low_asserts #(
   parameter int BANKS  = 8,
   parameter int BANK_W = 3
) (
   input wire logic                  clock,
   input wire logic                  sys_rst,
   input wire logic [8:0]            address,
   input wire logic                  read,
   input wire logic                  write,
   input wire logic [31:0]           writedata,
   input wire logic [3:0]            byteenable,
   input wire logic [31:0]           readdata,
   input wire logic                  waitrequest,
   input wire logic                  cmd_valid,
   input wire logic                  cmd_chan,
   input wire logic [BANK_W-1:0]     cmd_bank,
   input wire dtl_pkg::dtl_cmd_t     cmd_kind,
   input wire logic [1:0][BANKS-1:0] act_ok,
   input wire logic [1:0][BANKS-1:0] pre_ok,
   input wire logic [1:0][BANKS-1:0] ref_ok,
   input wire logic [1:0][7:0]       memory_clock_out
);
   // ----
   // Checks
   // ----
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic act_go;
   assign act_go = cmd_valid && cmd_kind == dtl_pkg::DTL_CMD_ACT && act_ok[cmd_chan][cmd_bank];
   a_clk_off_a: assert property (write && byteenable[3] && !waitrequest && address == 9'h088
      |-> ##2 memory_clock_out[0] == ~$past(writedata[31:24], 2)) else $error("mask a");
   a_clk_off_b: assert property (write && byteenable[3] && !waitrequest && address == 9'h188
      |-> ##2 memory_clock_out[1] == ~$past(writedata[31:24], 2)) else $error("mask b");
   a_reset_clk_off: assert property ($fell(sys_rst) |-> memory_clock_out == '0)
      else $error("clocks on");
   a_ok_after_reset: assert property ($fell(sys_rst) |-> &act_ok && &pre_ok && &ref_ok)
      else $error("flags low");
   a_same_bank_rc: assert property (act_go |=> !act_ok[$past(cmd_chan)][$past(cmd_bank)]
      && !ref_ok[$past(cmd_chan)][$past(cmd_bank)]) else $error("row cycle");
   a_cross_bank_rrd: assert property (act_go |=> act_ok[$past(cmd_chan)] == '0)
      else $error("cross bank");
   a_act_pre_ras: assert property (act_go |=> !pre_ok[$past(cmd_chan)][$past(cmd_bank)])
      else $error("row active");
   a_unmapped_zero: assert property (read && !waitrequest && address != 9'h088
      && address != 9'h188 |-> readdata == '0) else $error("unmapped");
endmodule // dtl_timing_low_asserts
bind dtl_timing_low dtl_timing_low_asserts #(.BANKS(BANKS), .BANK_W(BANK_W)) u_dtl_timing_low_asserts (.clock,
   .sys_rst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .cmd_valid, .cmd_chan,
   .cmd_bank, .cmd_kind, .act_ok, .pre_ok, .ref_ok, .memory_clock_out);
`default_nettype wire

/* testbench/dtl_dram_model.sv */
// Memory side: marks rows opened by activates per bank; no command closes them.
// Assumes the block's command stream on one clock.
`timescale 1ns/1ns
`default_nettype none
module dtl_dram_model (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic [1:0][7:0]   memory_clock_out,
   input  wire logic              cmd_valid,
   input  wire logic              cmd_chan,
   input  wire logic [2:0]        cmd_bank,
   input  wire dtl_pkg::dtl_cmd_t cmd_kind,
   input  wire logic [1:0][7:0]   act_ok,
   output var  logic [1:0][7:0]   open_rows
);
   // ----
   // Row state
   // ----
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         open_rows <= '0;
      end else if (cmd_valid && memory_clock_out[cmd_chan] != 8'h00) begin
         if (cmd_kind == dtl_pkg::DTL_CMD_ACT && act_ok[cmd_chan][cmd_bank]) begin
            open_rows[cmd_chan][cmd_bank] <= 1'b1;
         end
      end
   end
endmodule // dtl_dram_model
`default_nettype wire

/* testbench/tb_dtl_timing_low.sv */
// Bench: register access and command spacing.
// Assumes design, checker and memory model compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "dtl_timing_regs.svh"
module tb_dtl_timing_low;
   // ----
   // Stimulus and checks
   // ----
   logic clock = 0, sys_rst = 1, read = 0, write = 0, cmd_valid = 0, cmd_chan = 0, third_gen_select = 0;
   logic [8:0] address = 0;
   logic [31:0] writedata = 0, readdata, q;
   logic [3:0] byteenable = 4'hf;
   logic [2:0] mem_clock_freq_code = 0, cmd_bank = 0;
   logic [5:0] wr_recovery_ext = 6'h09;
   logic waitrequest;
   logic [1:0][7:0] act_ok, pre_ok, ref_ok, memory_clock_out, open_rows;
   dtl_pkg::dtl_cmd_t cmd_kind = dtl_pkg::DTL_CMD_ACT;
   int fail_count = 0, cmp_count = 0, n;
   always #50 clock = ~clock;
   dtl_timing_low u_dtl_timing_low (.clock, .sys_rst, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .third_gen_select, .mem_clock_freq_code, .wr_recovery_ext, .cmd_valid,
      .cmd_chan, .cmd_bank, .cmd_kind, .act_ok, .pre_ok, .ref_ok, .memory_clock_out);
   dtl_dram_model u_dtl_dram_model (.clock, .sys_rst, .memory_clock_out, .cmd_valid, .cmd_chan, .cmd_bank,
      .cmd_kind, .act_ok, .open_rows);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clock);
      read <= ~w;
      write <= w;
      address <= a;
      writedata <= d;
      byteenable <= be;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic run(input logic ch, input logic [31:0] v, input logic tg, input logic [2:0] fq,
                      input dtl_pkg::dtl_cmd_t kd, input int sel, input int wb, input int exp);
      logic [7:0] f;
      third_gen_select <= tg;
      mem_clock_freq_code <= fq;
      bus(1'b1, ch ? `DTL_OFF_CHAN_B : `DTL_OFF_CHAN_A, v, 4'hf);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_chan <= ch;
      cmd_bank <= 3'h0;
      cmd_kind <= kd;
      @(posedge clock);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         n++;
         f = (sel == 0) ? act_ok[ch] : (sel == 1) ? pre_ok[ch] : ref_ok[ch];
      end while (f[wb] !== 1'b1 && n < 60);
      check("spacing", n, exp);
      repeat (50) @(posedge clock);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      bus(1'b0, `DTL_OFF_CHAN_A, 32'h0, 4'hf);
      check("reg a reset", q, `DTL_RESET);
      check("clocks off", memory_clock_out, 32'h0);
      bus(1'b0, 9'h100, 32'h0, 4'hf);
      check("unmapped", q, 32'h0);
      bus(1'b1, `DTL_OFF_CHAN_A, 32'h5a9f7fff, 4'hf);
      bus(1'b0, `DTL_OFF_CHAN_A, 32'h0, 4'hf);
      check("reg a", q, 32'h5a9f7000);
      check("clocks a", memory_clock_out[0], 8'ha5);
      check("clocks b", memory_clock_out[1], 8'h00);
      bus(1'b1, `DTL_OFF_CHAN_B, 32'h0fffffff, 4'h8);
      bus(1'b0, `DTL_OFF_CHAN_B, 32'h0, 4'hf);
      check("reg b", q, 32'h0f000000);
      check("clocks b", memory_clock_out[1], 8'hf0);
      for (int m = 0; m < 3; m++) begin
         for (int i = 0; i < 4; i++) begin
            run(1'b0, {8'h00, 2'(i), 22'h0}, m == 1, (m == 2) ? 3'h4 : 3'h3, dtl_pkg::DTL_CMD_ACT, 0, 1,
                i + ((m == 0) ? 2 : 4));
         end
      end
      run(1'b0, 32'h000f0000, 1'b0, 3'h3, dtl_pkg::DTL_CMD_ACT, 0, 0, 26);
      run(1'b0, 32'h00000000, 1'b0, 3'h3, dtl_pkg::DTL_CMD_ACT, 2, 0, 11);
      run(1'b0, 32'h00050000, 1'b0, 3'h3, dtl_pkg::DTL_CMD_REF, 0, 0, 16);
      run(1'b0, 32'h001f0000, 1'b1, 3'h3, dtl_pkg::DTL_CMD_ACT, 0, 0, 42);
      run(1'b0, 32'h00300000, 1'b0, 3'h4, dtl_pkg::DTL_CMD_ACT, 0, 0, 27);
      run(1'b0, 32'h00102000, 1'b0, 3'h3, dtl_pkg::DTL_CMD_ACT, 1, 0, 5);
      run(1'b0, 32'h00300000, 1'b0, 3'h3, dtl_pkg::DTL_CMD_WR_LAST, 1, 0, 6);
      run(1'b0, 32'h00300000, 1'b1, 3'h3, dtl_pkg::DTL_CMD_WR_LAST, 1, 0, 9);
      run(1'b1, 32'h00c00000, 1'b0, 3'h3, dtl_pkg::DTL_CMD_ACT, 0, 1, 5);
      check("row open", open_rows[1][0], 1'b1);
      sys_rst <= 1'b1;
      @(posedge clock);
      sys_rst <= 1'b0;
      bus(1'b0, `DTL_OFF_CHAN_A, 32'h0, 4'hf);
      check("reg a again", q, `DTL_RESET);
      summarize();
   end
endmodule // tb_dtl_timing_low
`default_nettype wire
